/* src/cbc_bal_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "cbc_regs.vh"

module cbc_bal_timer #(
    parameter [25:0] SEC_CYCLES = `CBC_SEC_CYCLES
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        arst_n,
    // control
    input  wire        restart,
    input  wire        active,
    input  wire [3:0]  duration,
    // one-cycle pulse when the selected time has run out
    output reg         expire
);

    reg  [25:0] prescale_reg;
    reg  [11:0] secs_reg;
    reg  [11:0] limit;
    wire        tick = (prescale_reg == SEC_CYCLES - 26'h1);

    // duration code to seconds; reserved codes leave the timer off
    always @*
    begin
        case (duration)
            4'h1:    limit = `CBC_DUR_S_1;
            4'h2:    limit = `CBC_DUR_S_2;
            4'h3:    limit = `CBC_DUR_S_3;
            4'h4:    limit = `CBC_DUR_S_4;
            4'h5:    limit = `CBC_DUR_S_5;
            4'h6:    limit = `CBC_DUR_S_6;
            4'h7:    limit = `CBC_DUR_S_7;
            4'h8:    limit = `CBC_DUR_S_8;
            4'h9:    limit = `CBC_DUR_S_9;
            default: limit = 12'h000;
        endcase
    end

    // seconds counter; restart, active low or a zero limit clears it
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prescale_reg <= 26'h000_0000;
            secs_reg     <= 12'h000;
            expire       <= 1'b0;
        end
        else if (restart || !active || limit == 12'h000)
        begin
            prescale_reg <= 26'h000_0000;
            secs_reg     <= 12'h000;
            expire       <= 1'b0;
        end
        else if (tick)
        begin
            prescale_reg <= 26'h000_0000;
            secs_reg     <= secs_reg + 12'h001;
            expire       <= (secs_reg + 12'h001 == limit);
        end
        else
        begin
            prescale_reg <= prescale_reg + 26'h000_0001;
            expire       <= 1'b0;
        end
    end

endmodule // cbc_bal_timer

`default_nettype wire

/* src/cbc_holdoff.v */
`timescale 1ns/1ps
`default_nettype none

module cbc_holdoff (
    // clock and reset
    input  wire        ref_clk,
    input  wire        arst_n,
    // from the uart framing logic, holdoff from the register
    input  wire        stop_bit_done,
    input  wire        bit_tick,
    input  wire [7:0]  holdoff,
    // level: transmitter may start its response
    output reg         tx_permit
);

    reg [7:0] count_reg;

    // count bit periods after each received stop bit
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_reg <= 8'h00;
            tx_permit <= 1'b1;
        end
        else if (stop_bit_done)
        begin
            count_reg <= holdoff;
            tx_permit <= (holdoff == 8'h00);
        end
        else if (bit_tick && count_reg != 8'h00)
        begin
            count_reg <= count_reg - 8'h01;
            tx_permit <= (count_reg == 8'h01);
        end
    end

endmodule // cbc_holdoff

`default_nettype wire

/* src/cbc_regs.vh */
`ifndef CBC_REGS_VH
`define CBC_REGS_VH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define CBC_IDX_HOLDOFF      8'h12
`define CBC_IDX_BAL_CONFIG   8'h13
`define CBC_IDX_DRAIN_EN     8'h14
`define CBC_IDX_TEST_CONFIG  8'h1E

// ****************************************************************
// field positions
// ****************************************************************
`define CBC_DUR_MSB          7
`define CBC_DUR_LSB          4
`define CBC_KEEP_BIT         3
`define CBC_SQUEEZE_BIT      4

// ****************************************************************
// reset values
// ****************************************************************
`define CBC_HOLDOFF_RST      8'h00
`define CBC_BAL_CONFIG_RST   8'h00
`define CBC_DRAIN_EN_RST     16'h0000
`define CBC_TEST_CONFIG_RST  16'h0000

// ****************************************************************
// fault flags: the user checksum error never clears balancing
// ****************************************************************
`define CBC_FAULT_W          16
`define CBC_FAULT_CKSUM_BIT  0

// ****************************************************************
// timing: clock rate and balance durations in seconds
// ****************************************************************
// one second of the 40 MHz clock, sized to the prescaler width
`define CBC_SEC_CYCLES       26'h262_5A00
`define CBC_DUR_S_1          12'h001
`define CBC_DUR_S_2          12'h03C
`define CBC_DUR_S_3          12'h078
`define CBC_DUR_S_4          12'h12C
`define CBC_DUR_S_5          12'h258
`define CBC_DUR_S_6          12'h384
`define CBC_DUR_S_7          12'h4B0
`define CBC_DUR_S_8          12'h708
`define CBC_DUR_S_9          12'hE10

`endif

/* src/cbc_top.v */
// Summary of operation
// - transmitter waits holdoff bit periods after a received stop bit before responding.
// - duration code 0 off, 1 one second, 2..9 one to sixty minutes, rest reserved.
// - balance timer is separate from the comm timeout; traffic never restarts it.
// - any non-zero write to the drain enables restarts the balance timer.
// - keep-on-fault low and any fault but checksum set clears all drain enables.
// - under that same condition, writes to the drain enables are ignored.
// - keep-on-fault high makes faults irrelevant to the drain enables.
// - drain enable bit n drives output n for cell n+1; one means on.
// - wire-test select high routes enables to squeeze resistors, low to balancing.
// - balance config bits 2:0 read zero whatever is written.
// - wire-test select is bit 4 of the test configuration register.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cbc_regs.vh"

module cbc_top #(
    parameter [25:0] SEC_CYCLES = `CBC_SEC_CYCLES
) (
    // clock and reset
    input  wire                    ref_clk,
    input  wire                    arst_n,
    // apb slave
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [7:0]              paddr,
    input  wire [31:0]             pwdata,
    input  wire [3:0]              pstrb,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output wire                    pslverr,
    // fault flags from the fault registers
    input  wire [`CBC_FAULT_W-1:0] fault_flags,
    // uart framing handshake
    input  wire                    stop_bit_done,
    input  wire                    bit_tick,
    output wire                    tx_permit,
    // drain and squeeze drives, one per cell
    output reg  [15:0]             balance_drive,
    output reg  [15:0]             squeeze_drive,
    output reg                     wire_test_active
);

    // ****************************************************************
    // register storage
    // ****************************************************************
    reg  [7:0]  response_holdoff_reg;
    reg  [7:0]  balance_config_reg;
    reg  [15:0] cell_drain_enables_reg;
    reg  [15:0] cell_drain_enables_next;
    reg  [15:0] test_config_reg;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire        setup_phase  = psel && !penable;
    wire        access_phase = psel && penable;
    wire        wr_access    = access_phase && pwrite;
    wire [7:0]  reg_index    = {2'b00, paddr[7:2]};
    wire        hit_holdoff  = (reg_index == `CBC_IDX_HOLDOFF);
    wire        hit_config   = (reg_index == `CBC_IDX_BAL_CONFIG);
    wire        hit_drain    = (reg_index == `CBC_IDX_DRAIN_EN);
    wire        hit_test     = (reg_index == `CBC_IDX_TEST_CONFIG);
    wire        hit_any      = hit_holdoff || hit_config || hit_drain || hit_test;
    wire        aligned      = (paddr[1:0] == 2'b00);
    wire        mapped       = hit_any && aligned;

    // zero wait states; an unmapped or misaligned address errors
    assign pready  = 1'b1;
    assign pslverr = access_phase && !mapped;

    wire        wr_holdoff   = wr_access && mapped && hit_holdoff && pstrb[0];
    wire        wr_config    = wr_access && mapped && hit_config && pstrb[0];
    wire        wr_drain     = wr_access && mapped && hit_drain && (pstrb[1:0] != 2'b00);
    wire        wr_test      = wr_access && mapped && hit_test && pstrb[0];

    // ****************************************************************
    // fields
    // ****************************************************************
    wire [3:0]  balance_duration        =
        balance_config_reg[`CBC_DUR_MSB:`CBC_DUR_LSB];
    wire        keep_balancing_on_fault = balance_config_reg[`CBC_KEEP_BIT];
    wire        wire_test_resistor_select =
        test_config_reg[`CBC_SQUEEZE_BIT];

    // ****************************************************************
    // fault qualification
    // ****************************************************************
    // the user checksum error is masked out; it never stops balancing
    wire [`CBC_FAULT_W-1:0] fault_mask;
    genvar gi;
    generate
        for (gi = 0; gi < `CBC_FAULT_W; gi = gi + 1)
        begin : g_mask
            assign fault_mask[gi] = (gi != `CBC_FAULT_CKSUM_BIT);
        end
    endgenerate

    wire        user_checksum_error = fault_flags[`CBC_FAULT_CKSUM_BIT];
    wire        fault_active = |(fault_flags & fault_mask);
    // a held fault both clears and locks the enables unless kept on
    wire        fault_lock   = fault_active && !keep_balancing_on_fault;

    // ****************************************************************
    // drain enable write data with byte lanes
    // ****************************************************************
    reg  [15:0] drain_wdata;

    always @*
    begin
        drain_wdata = cell_drain_enables_reg;
        if (pstrb[0])
        begin
            drain_wdata[7:0] = pwdata[7:0];
        end
        if (pstrb[1])
        begin
            drain_wdata[15:8] = pwdata[15:8];
        end
    end

    // a locked write does not count, so it cannot restart the timer
    wire        drain_wr_ok  = wr_drain && !fault_lock;
    wire        timer_restart = drain_wr_ok && (drain_wdata != 16'h0000);

    // ****************************************************************
    // balance timer
    // ****************************************************************
    wire        timer_expire;

    // only the drain enable write restarts it; the uart has no path
    cbc_bal_timer #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_timer (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .restart    (timer_restart),
        .active     (cell_drain_enables_reg != 16'h0000),
        .duration   (balance_duration),
        .expire     (timer_expire)
    );

    // ****************************************************************
    // drain enable next value
    // ****************************************************************
    // fault clear beats everything; a fresh write beats a timer expiry,
    // since that write also restarts the timer
    always @*
    begin
        cell_drain_enables_next = cell_drain_enables_reg;
        if (fault_lock)
        begin
            cell_drain_enables_next = 16'h0000;
        end
        else if (drain_wr_ok)
        begin
            cell_drain_enables_next = drain_wdata;
        end
        else if (timer_expire)
        begin
            cell_drain_enables_next = 16'h0000;
        end
    end

    // ****************************************************************
    // register update
    // ****************************************************************
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            response_holdoff_reg   <= `CBC_HOLDOFF_RST;
            balance_config_reg     <= `CBC_BAL_CONFIG_RST;
            cell_drain_enables_reg <= `CBC_DRAIN_EN_RST;
            test_config_reg        <= `CBC_TEST_CONFIG_RST;
        end
        else
        begin
            cell_drain_enables_reg <= cell_drain_enables_next;
            if (wr_holdoff)
            begin
                response_holdoff_reg <= pwdata[7:0];
            end
            if (wr_config)
            begin
                // reserved low bits are never stored
                balance_config_reg <= {pwdata[7:3], 3'b000};
            end
            if (wr_test)
            begin
                // only the wire-test select is implemented here
                test_config_reg <= {11'h000, pwdata[`CBC_SQUEEZE_BIT], 4'h0};
            end
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // captured in the setup cycle; the access cycle shows that snapshot
    reg  [31:0] read_mux;

    always @*
    begin
        read_mux = 32'h0000_0000;
        case (reg_index)
            `CBC_IDX_HOLDOFF:
                read_mux = {24'h00_0000, response_holdoff_reg};
            `CBC_IDX_BAL_CONFIG:
                read_mux = {24'h00_0000, balance_config_reg[7:3], 3'b000};
            `CBC_IDX_DRAIN_EN:
                read_mux = {16'h0000, cell_drain_enables_reg};
            `CBC_IDX_TEST_CONFIG:
                read_mux = {16'h0000, test_config_reg};
            default:
                read_mux = 32'h0000_0000;
        endcase
        if (!aligned)
        begin
            read_mux = 32'h0000_0000;
        end
    end

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_phase && !pwrite)
        begin
            prdata <= read_mux;
        end
    end

    // ****************************************************************
    // output routing
    // ****************************************************************
    // registered so the external fets never see decode glitches
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            balance_drive    <= 16'h0000;
            squeeze_drive    <= 16'h0000;
            wire_test_active <= 1'b0;
        end
        else
        begin
            wire_test_active <= wire_test_resistor_select;
            if (wire_test_resistor_select)
            begin
                balance_drive <= 16'h0000;
                squeeze_drive <= cell_drain_enables_next;
            end
            else
            begin
                balance_drive <= cell_drain_enables_next;
                squeeze_drive <= 16'h0000;
            end
        end
    end

    // ****************************************************************
    // response holdoff
    // ****************************************************************
    // the checksum flag is deliberately unused past this point
    wire        unused_cksum = user_checksum_error;

    cbc_holdoff u_holdoff (
        .ref_clk       (ref_clk),
        .arst_n        (arst_n),
        .stop_bit_done (stop_bit_done),
        .bit_tick      (bit_tick),
        .holdoff       (response_holdoff_reg),
        .tx_permit     (tx_permit)
    );

endmodule // cbc_top

`default_nettype wire

/* tb/cbc_fet_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// drain fets across the cells
// ********
module cbc_fet_model (
    // gate drives from the block
    input wire logic [15:0] balance_drive,
    // cells being bled, bit n is cell n+1
    output logic     [15:0] bleed
);
    // a fet conducts whenever its gate is driven, no matter why it was driven
    assign bleed = balance_drive;
endmodule // cbc_fet_model
`default_nettype wire

/* tb/cbc_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// port relations of the balance control block
// ********
module cbc_top_monitor (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        arst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // faults and uart
    input wire logic [15:0] fault_flags,
    input wire logic        stop_bit_done,
    input wire logic        bit_tick,
    input wire logic        tx_permit,
    // drives
    input wire logic [15:0] balance_drive,
    input wire logic [15:0] squeeze_drive,
    input wire logic        wire_test_active
);
    logic       keep_q;
    logic [3:0] dur_q;
    logic [7:0] hold_q;
    logic [7:0] ticks;
    wire acc    = psel & penable;
    wire wr     = acc & pwrite & pstrb[0];
    wire wr_drn = wr & (paddr == 8'h50);
    wire blk    = !keep_q & (|fault_flags[15:1]);
    wire t_off  = (dur_q == 4'h0) | (dur_q > 4'h9);
    wire [15:0] drv = balance_drive | squeeze_drive;
    // shadow of the fields the relations hang on; the design keeps them inside
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
        begin
            keep_q <= 1'b0;
            dur_q  <= 4'h0;
            hold_q <= 8'h00;
            ticks  <= 8'h00;
        end
        else
        begin
            if (wr && paddr == 8'h4C)
            begin
                keep_q <= pwdata[3];
                dur_q  <= pwdata[7:4];
            end
            if (wr && paddr == 8'h48)
                hold_q <= pwdata[7:0];
            if (stop_bit_done)
                ticks <= 8'h00;
            else if (bit_tick)
                ticks <= ticks + 8'h01;
        end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_sq_only; wire_test_active |-> balance_drive == 16'h0000; endproperty
    a_sq_only: assert property (p_sq_only) else $error("balance on in wire test");
    property p_bal_only; !wire_test_active |-> squeeze_drive == 16'h0000; endproperty
    a_bal_only: assert property (p_bal_only) else $error("squeeze on in balance");
    property p_flt_clr; blk |=> drv == 16'h0000; endproperty
    a_flt_clr: assert property (p_flt_clr) else $error("fault left drain on");
    property p_wr_drop; blk ##1 (!blk && !wr_drn) |=> drv == 16'h0000; endproperty
    a_wr_drop: assert property (p_wr_drop) else $error("write in fault kept");
    property p_keep; keep_q && t_off && !wr_drn |=> $stable(drv); endproperty
    a_keep: assert property (p_keep) else $error("drain moved with keep set");
    property p_wr_map; wr_drn && pstrb[1] && !blk |=> drv == $past(pwdata[15:0]); endproperty
    a_wr_map: assert property (p_wr_map) else $error("drain write not applied");
    property p_rsvd; acc && !pwrite && paddr == 8'h4C |-> prdata[2:0] == 3'b000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("config low bits not zero");
    property p_tst_map; acc && paddr == 8'h78 |-> !pslverr; endproperty
    a_tst_map: assert property (p_tst_map) else $error("test config unmapped");
    property p_hold_lo; stop_bit_done && hold_q != 8'h00 |=> !tx_permit; endproperty
    a_hold_lo: assert property (p_hold_lo) else $error("permit after stop");
    property p_hold_hi; !tx_permit && bit_tick && ticks + 8'h01 == hold_q |=> tx_permit;
    endproperty
    a_hold_hi: assert property (p_hold_hi) else $error("permit late");
    property p_hold_early; !tx_permit && bit_tick && ticks + 8'h01 < hold_q |=> !tx_permit;
    endproperty
    a_hold_early: assert property (p_hold_early) else $error("permit early");
endmodule // cbc_top_monitor
bind cbc_top cbc_top_monitor mon_u (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pslverr(pslverr), .fault_flags(fault_flags),
    .stop_bit_done(stop_bit_done), .bit_tick(bit_tick), .tx_permit(tx_permit),
    .balance_drive(balance_drive), .squeeze_drive(squeeze_drive),
    .wire_test_active(wire_test_active));
`default_nettype wire

/* tb/cell_balance_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cell_balance_control_bench;
    localparam int SEC = 8;
    localparam logic [7:0] A_HLD = 8'h12 * 8'd4;
    localparam logic [7:0] A_CFG = 8'h13 * 8'd4;
    localparam logic [7:0] A_DRN = 8'h14 * 8'd4;
    localparam logic [7:0] A_TST = 8'h1E * 8'd4;
    localparam logic [31:0] A_ALL = {A_HLD, A_CFG, A_DRN, A_TST};
    // ********
    // stimulus, design and far side
    // ********
    logic        ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        stop_bit_done = 0, bit_tick = 0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, rd, rnd = 32'hc4b5_78d8;
    logic [15:0] fault_flags = 16'h0000;
    wire  [31:0] prdata;
    wire         pready, pslverr, tx_permit, wire_test_active;
    wire  [15:0] balance_drive, squeeze_drive, bleed;
    integer      n_fail = 0, tests_run = 0, cyc = 0, c, h, n, k;
    cbc_top #(.SEC_CYCLES(26'd8)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_flags(fault_flags), .stop_bit_done(stop_bit_done), .bit_tick(bit_tick),
        .tx_permit(tx_permit), .balance_drive(balance_drive),
        .squeeze_drive(squeeze_drive), .wire_test_active(wire_test_active));
    cbc_fet_model fet_u (.balance_drive(balance_drive), .bleed(bleed));
    // clock, and a ceiling well above the longest timer sweep
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 90000)
        begin
            n_fail = n_fail + 1;
            wrap_up;
        end
    end
    // ********
    // helpers
    // ********
    function logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // balance time in seconds for each duration code; zero means no timeout
    function integer dur_s(input integer code);
        case (code)
            1: dur_s = 1;
            2: dur_s = 60;
            3: dur_s = 120;
            4: dur_s = 300;
            5: dur_s = 600;
            6: dur_s = 900;
            7: dur_s = 1200;
            8: dur_s = 1800;
            9: dur_s = 3600;
            default: dur_s = 0;
        endcase
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; an idle cycle first keeps psel from two writes in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        // wait states end only on pready; the bench ceiling catches a hang
        @(posedge ref_clk);
        while (pready !== 1'b1)
        begin
            @(posedge ref_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask
    task pulse(input logic s);
        @(posedge ref_clk);
        stop_bit_done <= s;
        bit_tick <= !s;
        @(posedge ref_clk);
        stop_bit_done <= 0;
        bit_tick <= 0;
        #1;
    endtask
    task wrap_up;
        $display("mismatches %0d comparisons %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ********
    // main sequence
    // ********
    initial
    begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1;
        chk("permit_rst", 1, 32'(tx_permit));
        for (k = 0; k < 4; k = k + 1)
        begin
            apb(0, A_ALL[k*8 +: 8], 0);
            chk("reg_rst", 0, rd);
        end
        apb(1, 8'h7C, 32'hFFFF_FFFF);
        chk("bad_err", 1, 32'(err));
        apb(0, 8'h7C, 0);
        chk("bad_rd", 0, rd);
        // random register traffic, duration kept at zero so no timer runs
        repeat (6)
        begin
            rnd = lfsr(rnd);
            apb(1, A_CFG, rnd & 32'h0000_0008);
            apb(0, A_CFG, 0);
            chk("cfg", rnd & 32'h0000_0008, rd);
            apb(1, A_HLD, rnd);
            apb(0, A_HLD, 0);
            chk("hold", rnd & 32'h0000_00FF, rd);
            apb(1, A_DRN, rnd);
            chk("bleed", rnd & 32'h0000_FFFF, 32'(bleed));
            apb(0, A_DRN, 0);
            chk("drn", rnd & 32'h0000_FFFF, rd);
        end
        // routing follows the stored select, so drives move one edge after the write
        apb(1, A_TST, 32'h0000_0010);
        @(posedge ref_clk);
        #1 chk("sq", rnd & 32'h0000_FFFF, 32'(squeeze_drive));
        chk("bleed_wt", 0, 32'(bleed));
        chk("wt_on", 1, 32'(wire_test_active));
        apb(1, A_TST, 0);
        @(posedge ref_clk);
        #1 chk("bal_back", rnd & 32'h0000_FFFF, 32'(balance_drive));
        chk("wt_off", 0, 32'(wire_test_active));
        // faults with keep off: checksum ignored, others clear and lock
        apb(1, A_CFG, 0);
        apb(1, A_DRN, 32'h0000_A5C3);
        @(posedge ref_clk);
        fault_flags <= 16'h0001;
        repeat (3) @(posedge ref_clk);
        #1 chk("cksum", 32'h0000_A5C3, 32'(balance_drive));
        @(posedge ref_clk);
        fault_flags <= 16'h0008;
        repeat (2) @(posedge ref_clk);
        #1 chk("flt_clr", 0, 32'(balance_drive));
        apb(1, A_DRN, 32'h0000_00FF);
        chk("flt_wr", 0, 32'(balance_drive));
        // keep on: faults change nothing
        apb(1, A_CFG, 32'h0000_0008);
        apb(1, A_DRN, 32'h0000_3C3C);
        repeat (5) @(posedge ref_clk);
        #1 chk("keep", 32'h0000_3C3C, 32'(balance_drive));
        @(posedge ref_clk);
        fault_flags <= 16'h0000;
        // duration codes 0 to 10, uart traffic running meanwhile
        for (c = 0; c < 11; c = c + 1)
        begin
            apb(1, A_CFG, 32'(c << 4));
            apb(1, A_DRN, 32'h0000_8001);
            if (c == 1)
            begin
                repeat (2) @(posedge ref_clk);
                apb(1, A_DRN, 32'h0000_8001);
            end
            n = dur_s(c) * SEC;
            // last edge still on, the very next edge off unless the code has no timeout
            for (k = 0; k < (n != 0 ? n : 50); k = k + 1)
            begin
                @(posedge ref_clk);
                bit_tick <= k[0];
                stop_bit_done <= (k % 8 == 0);
            end
            #1 chk("timer_on", 32'h0000_8001, 32'(balance_drive));
            @(posedge ref_clk);
            bit_tick <= 0;
            stop_bit_done <= 0;
            #1 chk("timer_end", n != 0 ? 0 : 32'h0000_8001, 32'(balance_drive));
        end
        // holdoff counts bit ticks after a stop bit
        repeat (3)
        begin
            rnd = lfsr(rnd);
            h = rnd[2:0] + 1;
            apb(1, A_HLD, 32'(h));
            pulse(1);
            chk("hold_lo", 0, 32'(tx_permit));
            repeat (h - 1) pulse(0);
            chk("hold_wait", 0, 32'(tx_permit));
            pulse(0);
            chk("hold_hi", 1, 32'(tx_permit));
        end
        // park permit low first so a zero holdoff has to raise it
        pulse(1);
        chk("hold_lo2", 0, 32'(tx_permit));
        apb(1, A_HLD, 0);
        pulse(1);
        chk("hold_zero", 1, 32'(tx_permit));
        wrap_up;
    end
endmodule // cell_balance_control_bench
`default_nettype wire
